// ### hw/scs_top.v
// Conversion sequencer: start control, channel walk, delays, readback
`timescale 1ns/1ps
`include "scs_consts.vh"
module scs_top #(
   parameter INIT_SB_FX_0 = `SCS_INIT_SB_FX_0,
   parameter INIT_SB_AS_0 = `SCS_INIT_SB_AS_0,
   parameter INIT_SL_FX_0 = `SCS_INIT_SL_FX_0,
   parameter INIT_SL_AS_0 = `SCS_INIT_SL_AS_0
) (
   input wire sys_clk,
   input wire rstn,
   // Start pin, asynchronous
   input wire start_pin,
   // Serial clock and select pins, asynchronous
   input wire sclk_pin,
   input wire cs_n_pin,
   // Framing decode of the byte now being shifted
   input wire byte_is_pulse,
   input wire byte_is_aux_write,
   input wire [7:0] aux_write_data,
   // A data read is in progress on the serial side
   input wire read_active,
   // Configuration
   input wire auto_scan,
   input wire idle_sleep,
   input wire [1:0] conversion_rate_select,
   input wire [2:0] settling_delay_select,
   input wire [4:0] fixed_chan,
   input wire [28:0] chan_sel_mask,
   input wire chan_sel_wr,
   // Analog measurement inputs, millivolts, unsigned
   input wire [13:0] analog_positive_rail,
   input wire [13:0] analog_negative_rail,
   input wire [13:0] ext_ref_mv,
   // Modulator code for the channel being converted
   input wire [15:0] adc_code,
   // Outputs
   output wire result_ready_n,
   output wire [15:0] result_data,
   output wire [4:0] result_chan,
   output wire [4:0] chan_pointer,
   output wire converting,
   output wire in_standby,
   output wire in_sleep,
   output wire low_supply_flag,
   output wire [7:0] aux_pin_level_reg
);

   // Sequencer states
   localparam ST_IDLE = 2'd0;
   localparam ST_SETTLE = 2'd1;
   localparam ST_CONV = 2'd2;

   // Pick next selected channel after p, wrapping; p kept if none
   function [4:0] next_chan;
      input [28:0] mask;
      input [4:0] p;
      integer i;
      integer k;
      reg found;
      begin
         next_chan = p;
         found = 1'b0;
         for (i = 1; i <= `SCS_NCHAN; i = i + 1) begin
            k = (p + i) % `SCS_NCHAN;
            if (!found && mask[k]) begin
               next_chan = k[4:0];
               found = 1'b1;
            end
         end
      end
   endfunction

   // Millivolts to code at 3072 codes per volt
   function [15:0] mv_to_code;
      input [13:0] mv;
      reg [25:0] prod;
      begin
         prod = {12'd0, mv} * `SCS_CODES_PER_V;
         prod = prod / `SCS_MV_PER_V;
         mv_to_code = prod[15:0];
      end
   endfunction

   // Synchronised pins
   wire start_s;
   wire sclk_s;
   wire cs_n_s;

   // All three pins cross into the clock domain together
   scs_sync2 #(
      .W(3)
   ) u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .async_in({start_pin, sclk_pin, cs_n_pin}), // R24
      .sync_out({start_s, sclk_s, cs_n_s})
   );

   // Edge history registers
   reg start_d_q;
   reg sclk_d_q;
   // Serial falling-edge count within a byte
   reg [2:0] bit_cnt_q;
   // Sequencer state and cycle counter
   reg [1:0] state_q;
   reg [13:0] cnt_q;
   // Continue after this result
   reg keep_q;
   // Channel pointer and the channel being converted
   reg [4:0] ptr_q;
   reg [4:0] cur_q;
   // Result outputs
   reg ready_n_q;
   reg ready_pend_q;
   reg [15:0] data_q;
   reg [4:0] rchan_q;
   // Low-supply flag and aux pin level
   reg low_q;
   reg [7:0] aux_q;

   // Edge and byte events
   wire start_rise = start_s & ~start_d_q;
   wire sclk_fall = sclk_d_q & ~sclk_s & ~cs_n_s;
   wire byte_done = sclk_fall && (bit_cnt_q == `SCS_BYTE_LAST);
   wire pulse_cmd = byte_done & byte_is_pulse & ~start_s;

   // Supply difference in millivolts
   wire [13:0] supply_mv = analog_positive_rail - analog_negative_rail;

   // Channel selected by the pointer in the current mode
   wire [4:0] conv_chan = auto_scan ? ptr_q : fixed_chan;

   // Steady conversion period for the rate setting
   reg [13:0] conv_cyc;
   always @* begin
      case (conversion_rate_select)
         2'd3: conv_cyc = `SCS_CONV_CYC_3;
         2'd2: conv_cyc = `SCS_CONV_CYC_2;
         2'd1: conv_cyc = `SCS_CONV_CYC_1;
         default: conv_cyc = `SCS_CONV_CYC_0;
      endcase
   end

   // First-result delay: rate, idle kind and mode
   reg [13:0] init_cyc;
   always @* begin
      init_cyc = 14'd0;
      case ({idle_sleep, auto_scan, conversion_rate_select}) // R14
         4'b0011: init_cyc = `SCS_INIT_SB_FX_3; // R22
         4'b0010: init_cyc = `SCS_INIT_SB_FX_2;
         4'b0001: init_cyc = `SCS_INIT_SB_FX_1;
         4'b0000: init_cyc = INIT_SB_FX_0[13:0]; // R22
         4'b0111: init_cyc = `SCS_INIT_SB_AS_3;
         4'b0110: init_cyc = `SCS_INIT_SB_AS_2;
         4'b0101: init_cyc = `SCS_INIT_SB_AS_1;
         4'b0100: init_cyc = INIT_SB_AS_0[13:0];
         4'b1011: init_cyc = `SCS_INIT_SL_FX_3;
         4'b1010: init_cyc = `SCS_INIT_SL_FX_2;
         4'b1001: init_cyc = `SCS_INIT_SL_FX_1;
         4'b1000: init_cyc = INIT_SL_FX_0[13:0];
         4'b1111: init_cyc = `SCS_INIT_SL_AS_3;
         4'b1110: init_cyc = `SCS_INIT_SL_AS_2;
         4'b1101: init_cyc = `SCS_INIT_SL_AS_1;
         default: init_cyc = INIT_SL_AS_0[13:0];
      endcase
      // Added settling delay stacks on top of the table
      init_cyc = init_cyc + settling_delay_select * `SCS_DLY_STEP;
   end

   // Result value for the channel that just finished
   reg [15:0] result_val;
   always @* begin
      case (cur_q)
         // Supply collapses to zero while the flag is up
         `SCS_CH_SUPPLY: result_val = low_q ? 16'h0000 : // R16
            mv_to_code(supply_mv); // R18
         `SCS_CH_REF: result_val = mv_to_code(ext_ref_mv); // R20
         // Modulator already scales gain so unity is 30720
         `SCS_CH_GAIN: result_val = adc_code; // R19
         // Shorted inputs; any nonzero code is noise or offset
         `SCS_CH_OFFSET: result_val = adc_code; // R21
         default: result_val = adc_code;
      endcase
   end

   // Edge history for start and serial clock
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         start_d_q <= 1'b0;
         sclk_d_q <= 1'b0;
      end else begin
         start_d_q <= start_s; // R24
         sclk_d_q <= sclk_s;
      end
   end

   // Serial falling-edge counter; deselect restarts the byte
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_q <= 3'd0;
      end else if (cs_n_s) begin
         bit_cnt_q <= 3'd0;
      end else if (sclk_fall) begin
         bit_cnt_q <= bit_cnt_q + 3'd1;
      end
   end

   // Aux pin level takes the written byte at its last edge
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         aux_q <= 8'h00;
      end else if (byte_done && byte_is_aux_write) begin
         aux_q <= aux_write_data; // R13
      end
   end

   // Low-supply comparator with hysteresis
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         low_q <= 1'b0;
      end else if (supply_mv < `SCS_SUPPLY_TRIP_MV) begin
         low_q <= 1'b1; // R16
      end else if (supply_mv >=
                   `SCS_SUPPLY_TRIP_MV + `SCS_SUPPLY_HYST_MV) begin
         low_q <= 1'b0; // R17
      end
   end

   // Sequencer: state, counter, pointer and result capture
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         cnt_q <= 14'd0;
         keep_q <= 1'b0;
         ptr_q <= 5'd0;
         cur_q <= 5'd0;
         data_q <= 16'h0000;
         rchan_q <= 5'd0;
      end else begin
         // A select write reloads the pointer, even mid-scan
         if (chan_sel_wr) begin
            ptr_q <= next_chan(chan_sel_mask, 5'd28); // R6
         end
         case (state_q)
            ST_IDLE: begin
               // Start edge or pulse command opens a settling run
               if (start_rise || pulse_cmd) begin // R1 R9 R10
                  state_q <= ST_SETTLE;
                  cur_q <= conv_chan; // R1
                  cnt_q <= init_cyc - 14'd1; // R14
                  keep_q <= start_rise;
               end
            end
            ST_SETTLE, ST_CONV: begin
               // Judge the start level at the lookahead point
               if (cnt_q == `SCS_STOP_LOOKAHEAD) begin
                  keep_q <= keep_q & start_s; // R8 R3
               end
               if (cnt_q != 14'd0) begin
                  cnt_q <= cnt_q - 14'd1;
               end else begin
                  data_q <= result_val; // R12
                  rchan_q <= cur_q;
                  // Step the pointer only in scan mode
                  if (auto_scan && !chan_sel_wr) begin
                     ptr_q <= next_chan(chan_sel_mask, ptr_q); // R4 R5 R11
                  end
                  if (keep_q && start_s) begin
                     // Later results at the steady rate
                     state_q <= ST_CONV; // R2
                     cnt_q <= conv_cyc - 14'd1;
                     cur_q <= auto_scan ?
                        next_chan(chan_sel_mask, ptr_q) : fixed_chan; // R7
                  end else begin
                     state_q <= ST_IDLE; // R3 R8
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Ready output: low on a result, high on the first read edge.
   // A result arriving while still low pulses high for one cycle
   // so the host sees a fresh falling edge.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ready_n_q <= 1'b1;
         ready_pend_q <= 1'b0;
      end else if (state_q != ST_IDLE && cnt_q == 14'd0) begin
         // New result wins over a read edge in the same cycle
         if (!ready_n_q) begin
            ready_n_q <= 1'b1;
            ready_pend_q <= 1'b1;
         end else begin
            ready_n_q <= 1'b0; // R12
         end
      end else if (ready_pend_q) begin
         ready_n_q <= 1'b0; // R12
         ready_pend_q <= 1'b0;
      end else if (sclk_fall && read_active) begin
         ready_n_q <= 1'b1; // R23
      end
   end

   // Output drive
   assign result_ready_n = ready_n_q;
   assign result_data = data_q;
   assign result_chan = rchan_q;
   assign chan_pointer = auto_scan ? ptr_q : fixed_chan;
   assign converting = (state_q != ST_IDLE);
   assign in_standby = (state_q == ST_IDLE) & ~idle_sleep;
   assign in_sleep = (state_q == ST_IDLE) & idle_sleep;
   assign low_supply_flag = low_q;
   assign aux_pin_level_reg = aux_q;

endmodule

// ### hw/scs_consts.vh
// Constants for the scan conversion sequencer
// Overview of operation
// R1: Start rise begins converting at pointer channel
// R2: Start held high loops through programmed channels
// R3: Start low: finish conversion, then idle
// R4: After last selected channel, wrap to first
// R5: One channel in scan: repeat without advancing
// R6: Channel-select write resets pointer to first
// R7: Fixed-channel mode never advances the pointer
// R8: Start low before ready minus eight: single
// R9: Start low: each pulse command converts once
// R10: Pulse command acts on eighth falling edge
// R11: Pulse in scan mode advances to next channel
// R12: Ready output goes low when result available
// R13: Aux pin level updates on eighth falling edge
// R14: First result delayed per rate and idle kind
// R15: Host disables chopping before readback channels
// R16: Supply below 4.3V: zero result, flag set
// R17: Low-supply flag clears 50mV above trip
// R18: Supply readback is rail difference, 3072/V
// R19: Gain readback, 30720 codes mean unity
// R20: Reference readback scaled 3072 codes per volt
// R21: Offset readback ideally zero code
// R22: Fixed standby first delay 802 to 8866
// R23: Ready returns high on first read edge
// R24: Start input synchronised before edge detection
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH

// Channel space and readback channel numbers
`define SCS_NCHAN 29
`define SCS_CH_OFFSET 5'd24
`define SCS_CH_SUPPLY 5'd25
`define SCS_CH_TEMP 5'd26
`define SCS_CH_GAIN 5'd27
`define SCS_CH_REF 5'd28

// Readback scaling
`define SCS_CODES_PER_V 26'd3072
`define SCS_MV_PER_V 26'd1000
`define SCS_GAIN_UNITY 16'h7800
`define SCS_OFFSET_IDEAL 16'h0000

// Low-supply trip and release in millivolts
`define SCS_SUPPLY_TRIP_MV 14'd4300
`define SCS_SUPPLY_HYST_MV 14'd50

// Point before ready at which the start level is judged
`define SCS_STOP_LOOKAHEAD 14'd8

// Serial bits per byte, minus one
`define SCS_BYTE_LAST 3'd7

// First-result delay in clock cycles, standby, fixed channel
`define SCS_INIT_SB_FX_3 14'd802
`define SCS_INIT_SB_FX_2 14'd1186
`define SCS_INIT_SB_FX_1 14'd2722
`define SCS_INIT_SB_FX_0 8866
// Standby, auto-scan
`define SCS_INIT_SB_AS_3 14'd708
`define SCS_INIT_SB_AS_2 14'd1092
`define SCS_INIT_SB_AS_1 14'd2628
`define SCS_INIT_SB_AS_0 8772
// Sleep, fixed channel
`define SCS_INIT_SL_FX_3 14'd866
`define SCS_INIT_SL_FX_2 14'd1250
`define SCS_INIT_SL_FX_1 14'd2786
`define SCS_INIT_SL_FX_0 8930
// Sleep, auto-scan
`define SCS_INIT_SL_AS_3 14'd772
`define SCS_INIT_SL_AS_2 14'd1156
`define SCS_INIT_SL_AS_1 14'd2692
`define SCS_INIT_SL_AS_0 8836

// Steady conversion period per rate after the first result
`define SCS_CONV_CYC_3 14'd128
`define SCS_CONV_CYC_2 14'd256
`define SCS_CONV_CYC_1 14'd1024
`define SCS_CONV_CYC_0 14'd4096

// Extra cycles per step of the settling delay select
`define SCS_DLY_STEP 14'd64

`endif

// ### hw/scs_sync2.v
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
module scs_sync2 #(
   parameter W = 1
) (
   sys_clk,
   rstn,
   async_in,
   sync_out
);
   input wire sys_clk;
   input wire rstn;
   input wire [W-1:0] async_in;
   output wire [W-1:0] sync_out;

   // First stage, read only by the second stage
   reg [W-1:0] meta_q;
   // Second stage, safe for logic
   reg [W-1:0] sync_q;

   // Both stages clear to zero at reset
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule

// ### bench/scs_monitor.sv
// Checker on the conversion sequencer ports
`timescale 1ns/1ps
module scs_monitor (
   input wire sys_clk,
   input wire rstn,
   input wire start_pin,
   input wire byte_is_aux_write,
   input wire [7:0] aux_write_data,
   input wire read_active,
   input wire auto_scan,
   input wire [4:0] fixed_chan,
   input wire [28:0] chan_sel_mask,
   input wire chan_sel_wr,
   input wire [13:0] analog_positive_rail,
   input wire [13:0] analog_negative_rail,
   input wire result_ready_n,
   input wire [4:0] chan_pointer,
   input wire [4:0] result_chan,
   input wire converting,
   input wire low_supply_flag,
   input wire [7:0] aux_pin_level_reg
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Rail difference as the supply monitor sees it
   wire [13:0] sup = analog_positive_rail - analog_negative_rail;
   // Highest priority selected channel: lowest set bit
   function [4:0] lo_bit(input [28:0] m);
      integer i;
      begin
         lo_bit = 5'd0;
         for (i = 28; i >= 0; i = i - 1)
            if (m[i]) lo_bit = i[4:0];
      end
   endfunction
   // A result landing on an unread one shows its fall a cycle late
   a_ready_cause: assert property ($fell(result_ready_n) |->
      $past(converting) || $past(converting, 2))
      else $error("result without conversion");
   a_start_begins: assert property (!converting && $rose(start_pin)
      |-> ##[2:5] converting) else $error("start did not convert");
   a_start_synced: assert property ($rose(start_pin) && !converting
      |=> !converting) else $error("start acted unsynchronised");
   a_stop_result: assert property ($fell(converting) |->
      ##[0:1] !result_ready_n) else $error("stop without result");
   a_aux_update: assert property ($changed(aux_pin_level_reg) |->
      $past(byte_is_aux_write) && aux_pin_level_reg ==
      $past(aux_write_data)) else $error("aux level changed wrongly");
   a_ready_release: assert property ($rose(result_ready_n) &&
      !$past(read_active) |=> !result_ready_n)
      else $error("ready released without read");
   a_supply_trip: assert property ((sup < 14'd4300) [*5] |->
      low_supply_flag) else $error("low supply flag not set");
   a_supply_hold: assert property (low_supply_flag &&
      sup < 14'd4350 |=> low_supply_flag) else $error("flag left early");
   a_supply_release: assert property ((sup >= 14'd4350) [*5] |->
      !low_supply_flag) else $error("low supply flag stuck");
   // Every fixed-mode result must come from the fixed channel
   a_fixed_pointer: assert property ($fell(result_ready_n) &&
      !auto_scan |-> result_chan == fixed_chan)
      else $error("fixed pointer moved");
   a_select_resets: assert property (chan_sel_wr && auto_scan &&
      (|chan_sel_mask) |=> chan_pointer == lo_bit($past(chan_sel_mask)))
      else $error("select write kept old pointer");
   // Main scenarios reached
   cover property ($fell(result_ready_n));
   cover property ($fell(low_supply_flag));
   cover property ($changed(aux_pin_level_reg));
endmodule

// ### bench/scs_host_model.sv
// Host model on the serial side of the sequencer
`timescale 1ns/1ps
module scs_host_model (
   output logic sclk_pin,
   output logic cs_n_pin,
   output logic byte_is_pulse,
   output logic byte_is_aux_write,
   output logic [7:0] aux_write_data,
   output logic read_active
);
   // Link clock parks low, select high; chopping never on
   initial begin
      sclk_pin = 1'b0;
      cs_n_pin = 1'b1;
      byte_is_pulse = 1'b0;
      byte_is_aux_write = 1'b0;
      aux_write_data = 8'h00;
      read_active = 1'b0;
   end
   // Byte of n falling edges; fewer than 8 is a cut frame
   task xfer(input int n, input logic p, input logic a,
      input logic [7:0] d);
      cs_n_pin = 1'b0;
      byte_is_pulse = p;
      byte_is_aux_write = a;
      aux_write_data = d;
      repeat (n) begin
         #62.5 sclk_pin = 1'b1;
         #62.5 sclk_pin = 1'b0;
      end
      // Hold decode past the last edge so the sync stage sees it
      #62.5 cs_n_pin = 1'b1;
      byte_is_pulse = 1'b0;
      byte_is_aux_write = 1'b0;
      // Released data shows a changed value, never the old one
      aux_write_data = ~d;
   endtask
   // Start of a data read: one falling edge with read flagged
   task rd;
      read_active = 1'b1;
      cs_n_pin = 1'b0;
      #62.5 sclk_pin = 1'b1;
      #62.5 sclk_pin = 1'b0;
      #125 read_active = 1'b0;
      cs_n_pin = 1'b1;
   endtask
endmodule

// ### bench/scs_top_bench.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module scs_top_bench;
   logic sys_clk, rstn, start_pin, auto_scan, idle_sleep, chan_sel_wr;
   logic [1:0] conversion_rate_select;
   logic [2:0] settling_delay_select;
   logic [4:0] fixed_chan;
   logic [28:0] chan_sel_mask;
   logic [13:0] analog_positive_rail, analog_negative_rail, ext_ref_mv;
   logic [15:0] adc_code;
   wire sclk_pin, cs_n_pin, byte_is_pulse, byte_is_aux_write, read_active;
   wire [7:0] aux_write_data, aux_pin_level_reg;
   wire result_ready_n, converting, in_standby, in_sleep, low_supply_flag;
   wire [15:0] result_data;
   wire [4:0] result_chan, chan_pointer;
   int mismatches, checks_done;
   // Slowest first delay cut to 40 to keep the run short
   scs_top #(.INIT_SB_FX_0(40), .INIT_SB_AS_0(40), .INIT_SL_FX_0(40),
      .INIT_SL_AS_0(40)) dut_u (.*);
   scs_host_model h_u (.*);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task check(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Bench inputs move 1 ns after the edge; host model pins keep their own 62.5 ns steps
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task wait_rdy(output int n);
      n = 0;
      while (result_ready_n !== 1'b0) begin
         cyc(1);
         n++;
         if (n > 20000) begin
            mismatches++;
            conclude();
         end
      end
   endtask
   // Take one result, read it, see ready released
   task got(input logic [4:0] ch, input logic [15:0] d);
      int n;
      wait_rdy(n);
      check(result_chan, ch);
      check(result_data, d);
      h_u.rd();
      cyc(1);
      check(result_ready_n, 1);
   endtask
   task sel(input logic [28:0] m);
      chan_sel_mask = m;
      chan_sel_wr = 1'b1;
      cyc(1);
      chan_sel_wr = 1'b0;
   endtask
   task wait_idle;
      int n;
      n = 0;
      while (converting !== 1'b0 && n < 600) begin
         cyc(1);
         n++;
      end
      check(converting, 0);
      h_u.rd();
      cyc(1);
   endtask
   // Short start pulse in fixed mode: one result, then standby
   task t_single;
      int n;
      start_pin = 1'b1;
      cyc(4);
      start_pin = 1'b0;
      wait_rdy(n);
      check(n >= 38 && n <= 43, 1);
      got(5'd3, 16'h1234);
      cyc(200);
      check(result_ready_n, 1);
      check(converting, 0);
      check(in_standby, 1);
      $display("test single done");
   endtask
   // Fixed channel at the fast rate: steady loop, then delayed sleep exit
   task t_fixed;
      int n;
      conversion_rate_select = 2'd3;
      start_pin = 1'b1;
      wait_rdy(n);
      check(n >= 802 && n <= 809, 1);
      got(5'd3, 16'h1234);
      got(5'd3, 16'h1234);
      start_pin = 1'b0;
      wait_idle;
      idle_sleep = 1'b1;
      settling_delay_select = 3'd1;
      start_pin = 1'b1;
      cyc(4);
      start_pin = 1'b0;
      wait_rdy(n);
      check(n >= 928 && n <= 933, 1);
      got(5'd3, 16'h1234);
      settling_delay_select = 3'd0;
      $display("test fixed done");
   endtask
   // Held start walks the list with readbacks and wraps
   task t_scan;
      int n;
      auto_scan = 1'b1;
      idle_sleep = 1'b1;
      conversion_rate_select = 2'd3;
      adc_code = 16'h7800;
      sel(29'h1a000004);
      check(chan_pointer, 2);
      start_pin = 1'b1;
      wait_rdy(n);
      check(n >= 772 && n <= 779, 1);
      got(5'd2, 16'h7800);
      got(5'd25, 16'h3c00);
      got(5'd27, 16'h7800);
      got(5'd28, 16'h1e00);
      got(5'd2, 16'h7800);
      start_pin = 1'b0;
      wait_idle;
      check(in_sleep, 1);
      $display("test scan done");
   endtask
   // Pulse commands: cut frame refused, one result each
   task t_pulse;
      idle_sleep = 1'b0;
      sel(29'h00000210);
      h_u.xfer(7, 1'b1, 1'b0, 8'h00);
      cyc(100);
      check(converting, 0);
      h_u.xfer(8, 1'b1, 1'b0, 8'h00);
      got(5'd4, 16'h7800);
      check(chan_pointer, 9);
      cyc(800);
      check(result_ready_n, 1);
      conversion_rate_select = 2'd2;
      h_u.xfer(8, 1'b1, 1'b0, 8'h00);
      got(5'd9, 16'h7800);
      conversion_rate_select = 2'd1;
      sel(29'h00000040);
      repeat (2) begin
         h_u.xfer(8, 1'b1, 1'b0, 8'h00);
         got(5'd6, 16'h7800);
      end
      check(chan_pointer, 6);
      $display("test pulse done");
   endtask
   task t_aux;
      h_u.xfer(8, 1'b0, 1'b1, 8'ha5);
      cyc(2);
      check(aux_pin_level_reg, 8'ha5);
      h_u.xfer(7, 1'b0, 1'b1, 8'h3c);
      cyc(2);
      check(aux_pin_level_reg, 8'ha5);
      $display("test aux done");
   endtask
   // Supply trip, hysteresis edge, zeroed readback, offset
   task t_supply;
      sel(29'h02000000);
      analog_positive_rail = 14'd4299;
      cyc(5);
      check(low_supply_flag, 1);
      h_u.xfer(8, 1'b1, 1'b0, 8'h00);
      got(5'd25, 16'h0000);
      analog_positive_rail = 14'd4349;
      cyc(5);
      check(low_supply_flag, 1);
      analog_positive_rail = 14'd4350;
      cyc(5);
      check(low_supply_flag, 0);
      sel(29'h01000000);
      adc_code = 16'h0000;
      h_u.xfer(8, 1'b1, 1'b0, 8'h00);
      got(5'd24, 16'h0000);
      $display("test supply done");
   endtask
   initial begin
      start_pin = 1'b0;
      auto_scan = 1'b0;
      idle_sleep = 1'b0;
      chan_sel_wr = 1'b0;
      conversion_rate_select = 2'd0;
      settling_delay_select = 3'd0;
      fixed_chan = 5'd3;
      chan_sel_mask = 29'h0;
      analog_positive_rail = 14'd5000;
      analog_negative_rail = 14'd0;
      ext_ref_mv = 14'd2500;
      adc_code = 16'h1234;
      mismatches = 0;
      checks_done = 0;
      rstn = 1'b0;
      cyc(10);
      rstn = 1'b1;
      check(result_ready_n, 1);
      cyc(2);
      t_single;
      t_fixed;
      t_scan;
      t_pulse;
      t_aux;
      t_supply;
      conclude;
   end
endmodule
bind scs_top scs_monitor mon_u (.*);
